// File: mtf_pkg.sv
/*
 * shared constants and types of the main timer block: register map,
 * field positions, divider figures, bus carrier structs.
 * assumes a 32-bit avalon-mm slave port with byte addresses.
 */
`default_nettype none

package mtf_pkg;

   // ********************************************************
   // register map (byte addresses, one word each)
   // ********************************************************
   localparam logic [7:0] MTF_OFS_COUNT   = 8'h00;
   localparam logic [7:0] MTF_OFS_FLAGS2  = 8'h04;
   localparam logic [7:0] MTF_OFS_MASK2   = 8'h08;
   localparam logic [7:0] MTF_OFS_PORTA   = 8'h0C;
   localparam logic [7:0] MTF_OFS_DIR     = 8'h10;
   localparam logic [7:0] MTF_OFS_USE     = 8'h14;
   localparam logic [7:0] MTF_OFS_CHAN    = 8'h20;   // eight channels, 8'h20..8'h3C
   localparam logic [7:0] MTF_CHAN_MASK   = 8'hE3;   // bits that must match for a channel hit

   // ********************************************************
   // fields and reset values
   // ********************************************************
   localparam int         MTF_FLG_ROLL    = 7;       // rollover flag and its enable
   localparam int         MTF_FLG_PER     = 6;       // periodic flag and its enable
   localparam logic [7:0] MTF_FLG_BITS    = 8'hC0;   // implemented flag bits
   localparam logic [7:0] MTF_MSK_BITS    = 8'hC3;   // implemented mask bits
   localparam logic [7:0] MTF_PSEL_BITS   = 8'h03;   // prescale select field
   localparam logic [7:0] MTF_CAP_PINS    = 8'h07;   // pins that are capture inputs
   localparam logic [15:0] MTF_COUNT_MAX  = 16'hFFFF;
   localparam logic [15:0] MTF_CHAN_RST   = 16'hFFFF;

   // ********************************************************
   // divider figures
   // ********************************************************
   localparam logic [1:0] MTF_OSC_LAST    = 2'h3;    // oscillator divided by four
   localparam int         MTF_WRITE_WIN   = 64;      // bus cycles for the one prescale write
   localparam int         MTF_ACCUM_DIV   = 64;      // accumulator clock = bus / 64
   localparam int         MTF_PER_DIV     = 8192;    // periodic clock = bus / 2^13
   localparam logic [1:0] MTF_WDOG_LAST   = 2'h3;    // watchdog = periodic / 4

   // log2 of the prescale divisor 1, 4, 8, 16
   function automatic logic [2:0] mtf_pre_shift(input logic [1:0] sel);
      case (sel)
         2'h0:    mtf_pre_shift = 3'h0;
         2'h1:    mtf_pre_shift = 3'h2;
         2'h2:    mtf_pre_shift = 3'h3;
         default: mtf_pre_shift = 3'h4;
      endcase
   endfunction

   // ********************************************************
   // bus carriers and slave states
   // ********************************************************
   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } mtf_bus_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } mtf_bus_rsp_t;

   typedef enum logic [1:0] {
      MTF_BUS_IDLE = 2'b01,
      MTF_BUS_ACK  = 2'b10
   } mtf_bus_st_t;

endpackage

`default_nettype wire

// File: mtf_timer.sv
/*
 * main timer: oscillator divider, prescaler, 16-bit free-running counter,
 * post-scaler chains, channel registers and port a pin control,
 * with an avalon-mm slave for software.
 * assumes clk_i is the oscillator input and all inputs are synchronous.
 */
// Implementation choices: the address map and the Avalon-MM slave port.
// Contract
// - bus clock is oscillator divided by four
// - bus clock feeds four divider chains
// - two-bit select picks divisor 1,4,8,16
// - one 16-bit counter steps per prescaler pulse
// - main timer clocks post-scalers and counter
// - counter from zero, rollover sets flag
// - writing one clears a flag bit
// - counter read-only in normal modes
// - accumulator clock is bus divided by 64
// - periodic clock is bus divided by 2^13
// - watchdog divides periodic clock by four
// - capture and compare channels, 16-bit registers
// - each timer event has own enable, request (here only rollover and periodic; channel hits have neither)
// - port a low/upper bits shared with channels
// - bit three and seven have extra uses
// - first compare may drive bits seven to three
// - read gives pin or driver level
// - timer pins latch writes, do not drive
// - select codes 00,01,10,11 map to 1,4,8,16
// - prescale written once within 64 cycles (here special mode allows writes at any time)
// - enabled rollover flag raises request
`timescale 1ns/1ps
`default_nettype none

module mtf_timer
   import mtf_pkg::*;
(
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire mtf_bus_req_t avs_i,
   output var  mtf_bus_rsp_t avs_o,
   input  wire logic         special_mode_i,
   input  wire logic [3:0]   capture_i,
   input  wire logic [7:0]   timer_level_i,
   input  wire logic [7:0]   pa_in_i,
   output logic      [7:0]   pa_out_o,
   output logic      [7:0]   pa_oe_o,
   output logic      [15:0]  count_o,
   output logic      [7:0]   compare_hit_o,
   output logic              serial_tick_o,
   output logic              main_tick_o,
   output logic              accum_tick_o,
   output logic              periodic_tick_o,
   output logic              watchdog_tick_o,
   output logic              rollover_irq_o,
   output logic              periodic_irq_o
);

   // ********************************************************
   // state
   // ********************************************************
   typedef struct packed {
      mtf_bus_st_t       bus_st;
      logic              waitreq;
      logic [31:0]       rdata;
      logic [1:0]        osc;
      logic [3:0]        pre;
      logic [15:0]       count;
      logic [5:0]        accum;
      logic [12:0]       per;
      logic [1:0]        wdog;
      logic [6:0]        boot;
      logic              locked;
      logic [7:0]        flags2;
      logic [7:0]        mask2;
      logic [7:0]        latch;
      logic [7:0]        dir;
      logic [7:0]        use_t;
      logic [7:0]        pa_out;
      logic [7:0]        pa_oe;
      logic [7:0][15:0]  chan;
      logic [7:0]        hit;
      logic              ser_tk;
      logic              main_tk;
      logic              acc_tk;
      logic              per_tk;
      logic              wd_tk;
      logic              roll_irq;
      logic              per_irq;
   } mtf_state_t;

   mtf_state_t s_ff;
   mtf_state_t nxt_s;

   // channel 3 captures while its pin direction is clear
   logic [7:0] cap_chan;
   assign cap_chan = {4'h0, ~s_ff.dir[3], 3'h7};

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
      merge16 = old;
      if (be[0]) begin
         merge16[7:0] = wd[7:0];
      end
      if (be[1]) begin
         merge16[15:8] = wd[15:8];
      end
   endfunction

   // ********************************************************
   // next state
   // ********************************************************
   always_comb begin
      logic        ph2;
      logic        mtk;
      logic        roll_ev;
      logic        per_ev;
      logic        wr;
      logic        win;
      logic [7:0]  clr;
      logic [7:0]  rd8;
      logic [15:0] rd16;
      logic [2:0]  sh;
      logic [3:0]  pre_last;
      logic [5:0]  acc_last;
      logic [12:0] per_last;
      logic [2:0]  ci;
      ph2      = 1'b0;
      mtk      = 1'b0;
      roll_ev  = 1'b0;
      per_ev   = 1'b0;
      clr      = 8'h00;
      rd8      = 8'h00;
      rd16     = 16'h0000;
      nxt_s    = s_ff;
      ci       = avs_i.address[4:2];
      wr       = avs_i.write && (s_ff.bus_st == MTF_BUS_ACK);
      sh       = mtf_pre_shift(s_ff.mask2[1:0]);
      pre_last = 4'((5'h01 << sh) - 5'h01);
      acc_last = 6'((MTF_ACCUM_DIV >> sh) - 1);
      per_last = 13'((MTF_PER_DIV >> sh) - 1);

      // oscillator divided by four gives the bus cycle
      nxt_s.osc = s_ff.osc + 2'h1;
      ph2       = (s_ff.osc == MTF_OSC_LAST);

      // prescaler; a >= compare survives a shrinking divisor
      if (ph2) begin
         if (s_ff.pre >= pre_last) begin
            nxt_s.pre = 4'h0;
            mtk       = 1'b1;
         end else begin
            nxt_s.pre = s_ff.pre + 4'h1;
         end
      end

      // free-running counter and rollover
      if (mtk) begin
         nxt_s.count = s_ff.count + 16'h0001;
         roll_ev     = (s_ff.count == MTF_COUNT_MAX);
      end

      // post-scalers driven by the main timer
      if (mtk) begin
         nxt_s.accum = (s_ff.accum >= acc_last) ? 6'h00 : s_ff.accum + 6'h01;
         if (s_ff.per >= per_last) begin
            nxt_s.per = 13'h0000;
            per_ev    = 1'b1;
            nxt_s.wdog = s_ff.wdog + 2'h1;
         end else begin
            nxt_s.per = s_ff.per + 13'h0001;
         end
      end

      // derived clock pulses, one cycle each
      nxt_s.ser_tk  = ph2;
      nxt_s.main_tk = mtk;
      nxt_s.acc_tk  = mtk && (s_ff.accum >= acc_last);
      nxt_s.per_tk  = per_ev;
      nxt_s.wd_tk   = per_ev && (s_ff.wdog == MTF_WDOG_LAST);

      // bus cycles since reset, saturating past the write window
      if (ph2 && (s_ff.boot < 7'(MTF_WRITE_WIN))) begin
         nxt_s.boot = s_ff.boot + 7'h01;
      end
      win = special_mode_i || (!s_ff.locked && (s_ff.boot < 7'(MTF_WRITE_WIN)));

      // channels: capture strobes and compare hits
      for (int i = 0; i < 8; i++) begin
         if (cap_chan[i] && (i < 4) && capture_i[i[1:0]]) begin
            nxt_s.chan[i] = s_ff.count;
         end
         nxt_s.hit[i] = !cap_chan[i] && mtk && (s_ff.chan[i] == s_ff.count);
      end

      // register read mux
      case (avs_i.address)
         MTF_OFS_COUNT:  rd16 = s_ff.count;
         MTF_OFS_FLAGS2: rd8  = s_ff.flags2 & MTF_FLG_BITS;
         MTF_OFS_MASK2:  rd8  = s_ff.mask2 & MTF_MSK_BITS;
         MTF_OFS_PORTA:  rd8  = (s_ff.pa_oe & s_ff.pa_out) | (~s_ff.pa_oe & pa_in_i);
         MTF_OFS_DIR:    rd8  = s_ff.dir;
         MTF_OFS_USE:    rd8  = s_ff.use_t;
         default: begin
            if ((avs_i.address & MTF_CHAN_MASK) == MTF_OFS_CHAN) begin
               rd16 = s_ff.chan[ci];
            end
         end
      endcase

      // slave: answer one cycle after the request, act at the release edge
      case (s_ff.bus_st)
         MTF_BUS_IDLE: begin
            if (avs_i.read || avs_i.write) begin
               nxt_s.bus_st  = MTF_BUS_ACK;
               nxt_s.waitreq = 1'b0;
               nxt_s.rdata   = {16'h0000, rd16 | {8'h00, rd8}};
            end
         end
         MTF_BUS_ACK: begin
            nxt_s.bus_st  = MTF_BUS_IDLE;
            nxt_s.waitreq = 1'b1;
            nxt_s.rdata   = 32'h0000_0000;
         end
         default: begin
            nxt_s.bus_st  = MTF_BUS_IDLE;
            nxt_s.waitreq = 1'b1;
         end
      endcase

      // register writes
      if (wr && avs_i.byteenable[0]) begin
         case (avs_i.address)
            MTF_OFS_FLAGS2: clr = avs_i.writedata[7:0] & MTF_FLG_BITS;
            MTF_OFS_MASK2: begin
               nxt_s.mask2[7:6] = avs_i.writedata[7:6];
               if (win) begin
                  nxt_s.mask2[1:0] = avs_i.writedata[1:0];
                  nxt_s.locked     = 1'b1;
               end
            end
            MTF_OFS_PORTA: nxt_s.latch = avs_i.writedata[7:0];
            MTF_OFS_DIR:   nxt_s.dir   = avs_i.writedata[7:0];
            MTF_OFS_USE:   nxt_s.use_t = avs_i.writedata[7:0];
            default: ;
         endcase
      end
      if (wr && (avs_i.address == MTF_OFS_COUNT) && special_mode_i) begin
         nxt_s.count = merge16(s_ff.count, avs_i.writedata, avs_i.byteenable);
      end
      if (wr && ((avs_i.address & MTF_CHAN_MASK) == MTF_OFS_CHAN)) begin
         nxt_s.chan[ci] = merge16(s_ff.chan[ci], avs_i.writedata, avs_i.byteenable);
      end

      // sticky flags: a new event beats a clearing write
      nxt_s.flags2 = s_ff.flags2 & ~clr;
      if (roll_ev) begin
         nxt_s.flags2[MTF_FLG_ROLL] = 1'b1;
      end
      if (per_ev) begin
         nxt_s.flags2[MTF_FLG_PER] = 1'b1;
      end

      // separate requests per event
      nxt_s.roll_irq = nxt_s.flags2[MTF_FLG_ROLL] && nxt_s.mask2[MTF_FLG_ROLL];
      nxt_s.per_irq  = nxt_s.flags2[MTF_FLG_PER] && nxt_s.mask2[MTF_FLG_PER];

      // port a: timer pins follow the channel level, never the latch
      for (int i = 0; i < 8; i++) begin
         nxt_s.pa_out[i] = nxt_s.use_t[i] ? timer_level_i[i] : nxt_s.latch[i];
         nxt_s.pa_oe[i]  = nxt_s.dir[i] && !(nxt_s.use_t[i] && MTF_CAP_PINS[i]);
      end
   end

   // ********************************************************
   // state register
   // ********************************************************
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         s_ff         <= '0;
         s_ff.bus_st  <= MTF_BUS_IDLE;
         s_ff.waitreq <= 1'b1;
         s_ff.chan    <= {8{MTF_CHAN_RST}};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // outputs straight from the state; first compare may own bits 7:3
   assign avs_o.readdata    = s_ff.rdata;
   assign avs_o.waitrequest = s_ff.waitreq;
   assign pa_out_o          = s_ff.pa_out;
   assign pa_oe_o           = s_ff.pa_oe;
   assign count_o           = s_ff.count;
   assign compare_hit_o     = s_ff.hit;
   assign serial_tick_o     = s_ff.ser_tk;
   assign main_tick_o       = s_ff.main_tk;
   assign accum_tick_o      = s_ff.acc_tk;
   assign periodic_tick_o   = s_ff.per_tk;
   assign watchdog_tick_o   = s_ff.wd_tk;
   assign rollover_irq_o    = s_ff.roll_irq;
   assign periodic_irq_o    = s_ff.per_irq;

   // ********************************************************
   // checks
   // ********************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   property p_bus_div;
      serial_tick_o |=> !serial_tick_o [*3] ##1 serial_tick_o;
   endproperty
   a_bus_div: assert property (p_bus_div) else $error("bus tick not every fourth cycle");

   property p_div_one;
      (s_ff.mask2[1:0] == 2'h0) && serial_tick_o && $stable(s_ff.mask2) |-> main_tick_o;
   endproperty
   a_div_one: assert property (p_div_one) else $error("divisor one missed a main tick");

   property p_roll;
      (s_ff.osc == MTF_OSC_LAST) && (s_ff.pre >= 4'((5'h01 << mtf_pre_shift(s_ff.mask2[1:0])) - 5'h01))
         && (count_o == MTF_COUNT_MAX) |=> (count_o == 16'h0000) && s_ff.flags2[MTF_FLG_ROLL];
   endproperty
   a_roll: assert property (p_roll) else $error("rollover did not wrap and flag");

   property p_clear;
      (s_ff.bus_st == MTF_BUS_ACK) && avs_i.write && avs_i.byteenable[0] && (avs_i.address == MTF_OFS_FLAGS2)
         && avs_i.writedata[MTF_FLG_ROLL] && !(main_tick_o && count_o == 16'h0000)
         && !((s_ff.osc == MTF_OSC_LAST) && (count_o == MTF_COUNT_MAX))
         |=> !s_ff.flags2[MTF_FLG_ROLL];
   endproperty
   a_clear: assert property (p_clear) else $error("write of one did not clear rollover flag");

   property p_readonly;
      !special_mode_i && (s_ff.osc != MTF_OSC_LAST) |=> $stable(count_o);
   endproperty
   a_readonly: assert property (p_readonly) else $error("counter changed without a main tick");

   property p_lock;
      !special_mode_i && s_ff.locked |=> $stable(s_ff.mask2[1:0]);
   endproperty
   a_lock: assert property (p_lock) else $error("prescale changed after its one write");

   property p_irq;
      s_ff.flags2[MTF_FLG_ROLL] && s_ff.mask2[MTF_FLG_ROLL] && $stable(s_ff.flags2)
         && $stable(s_ff.mask2) |-> rollover_irq_o;
   endproperty
   a_irq: assert property (p_irq) else $error("enabled rollover flag raised no request");

   property p_set_wins;
      (s_ff.osc == MTF_OSC_LAST) && (s_ff.mask2[1:0] == 2'h0) && (count_o == MTF_COUNT_MAX)
         && (s_ff.bus_st == MTF_BUS_ACK) && avs_i.write && (avs_i.address == MTF_OFS_FLAGS2)
         |=> s_ff.flags2[MTF_FLG_ROLL];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("rollover lost to clearing write");

   property p_wdog;
      watchdog_tick_o |-> periodic_tick_o;
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog tick without periodic tick");

   property p_reset;
      disable iff (1'b0) !rstn_i |=> (s_ff.pre == 4'h0) && (s_ff.per == 13'h0000) && (count_o == 16'h0000);
   endproperty
   a_reset: assert property (p_reset) else $error("divider stage not cleared by reset");

endmodule

`default_nettype wire

// File: tb_mtf_timer.sv
/*
 * self-checking bench of the main timer: bus reads and writes, tick
 * spacing, rollover flag, port a pin control.
 * assumes mtf_pkg and mtf_timer are compiled first; single 50 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none

module tb_mtf_timer
   import mtf_pkg::*;
;
   // ****************************************
   // signals
   // ****************************************
   logic         clk_i;
   logic         rstn_i;
   mtf_bus_req_t req;
   mtf_bus_rsp_t rsp;
   logic         special_mode_i;
   logic [3:0]   capture_i;
   logic [7:0]   timer_level_i;
   logic [7:0]   pa_in_i;
   logic [7:0]   pa_out_o;
   logic [7:0]   pa_oe_o;
   logic [15:0]  count_o;
   logic [7:0]   hit_o;
   logic [4:0]   ticks;
   logic [1:0]   irq;
   int           error_cnt;
   int           num_checks;
   logic [31:0]  q;
   int           n;

   mtf_timer dut (
      .clk_i           (clk_i),
      .rstn_i          (rstn_i),
      .avs_i           (req),
      .avs_o           (rsp),
      .special_mode_i  (special_mode_i),
      .capture_i       (capture_i),
      .timer_level_i   (timer_level_i),
      .pa_in_i         (pa_in_i),
      .pa_out_o        (pa_out_o),
      .pa_oe_o         (pa_oe_o),
      .count_o         (count_o),
      .compare_hit_o   (hit_o),
      .serial_tick_o   (ticks[0]),
      .main_tick_o     (ticks[1]),
      .accum_tick_o    (ticks[2]),
      .periodic_tick_o (ticks[3]),
      .watchdog_tick_o (ticks[4]),
      .rollover_irq_o  (irq[0]),
      .periodic_irq_o  (irq[1])
   );

   // clock at 20 ns period
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end

   // ****************************************
   // tasks
   // ****************************************
   // verdict and end of run
   task automatic final_report();
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // compare two values
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // one avalon access, held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      req.read       <= ~wr;
      req.write      <= wr;
      req.address    <= a;
      req.writedata  <= d;
      req.byteenable <= 4'hF;
      @(posedge clk_i);
      while (rsp.waitrequest !== 1'b0) begin
         @(posedge clk_i);
      end
      q = rsp.readdata;
      req.read  <= 1'b0;
      req.write <= 1'b0;
   endtask

   // cycles between two pulses of tick k
   task automatic measure(input int k, output int cnt);
      int i;
      i = 0;
      cnt = 0;
      @(posedge clk_i);
      while (ticks[k] !== 1'b1 && i < 70000) begin
         @(posedge clk_i);
         i++;
      end
      do begin
         @(posedge clk_i);
         cnt++;
      end while (ticks[k] !== 1'b1 && cnt < 70000);
   endtask

   // ****************************************
   // watchdog
   // ****************************************
   initial begin
      repeat (90000) @(posedge clk_i);
      error_cnt++;
      final_report();
   end

   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      error_cnt      = 0;
      num_checks     = 0;
      rstn_i         = 1'b0;
      req            = '0;
      special_mode_i = 1'b0;
      capture_i      = 4'h0;
      timer_level_i  = 8'h0F;
      pa_in_i        = 8'h3C;
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      // one prescale write in normal mode, later one ignored
      bus(1'b1, MTF_OFS_MASK2, 32'h0000_0001);
      bus(1'b1, MTF_OFS_MASK2, 32'h0000_0003);
      bus(1'b0, MTF_OFS_MASK2, 32'h0);
      chk(q, 32'h0000_0001);
      measure(1, n);
      chk(n, 16);
      measure(0, n);
      chk(n, 4);
      // reset values and an unmapped place
      bus(1'b0, MTF_OFS_FLAGS2, 32'h0);
      chk(q, 32'h0);
      bus(1'b0, MTF_OFS_CHAN, 32'h0);
      chk(q, {16'h0, MTF_CHAN_RST});
      bus(1'b0, 8'h18, 32'h0);
      chk(q, 32'h0);
      // counter ignores writes in normal mode
      bus(1'b1, MTF_OFS_COUNT, 32'h0000_FFF0);
      bus(1'b0, MTF_OFS_COUNT, 32'h0);
      chk({31'h0, q < 32'h100}, 32'h1);
      // port a: pin level for inputs, driver level for outputs
      bus(1'b1, MTF_OFS_DIR, 32'h0000_00F0);
      bus(1'b1, MTF_OFS_USE, 32'h0);
      bus(1'b1, MTF_OFS_PORTA, 32'h0000_00A5);
      bus(1'b0, MTF_OFS_PORTA, 32'h0);
      chk(q, 32'h0000_00AC);
      chk({24'h0, pa_out_o & pa_oe_o}, 32'h0000_00A0);
      chk({24'h0, pa_oe_o}, 32'h0000_00F0);
      // timer-owned pins latch writes but do not drive them
      bus(1'b1, MTF_OFS_USE, 32'h0000_0070);
      bus(1'b1, MTF_OFS_PORTA, 32'h0000_00FF);
      bus(1'b0, MTF_OFS_PORTA, 32'h0);
      chk(q, 32'h0000_008C);
      chk({24'h0, pa_out_o & pa_oe_o}, 32'h0000_0080);
      bus(1'b1, MTF_OFS_USE, 32'h0);
      bus(1'b0, MTF_OFS_PORTA, 32'h0);
      chk(q, 32'h0000_00FC);
      // special mode: every prescale code
      special_mode_i <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, MTF_OFS_MASK2, s);
         measure(1, n);
         chk(n, 4 * ((s == 0) ? 1 : (s == 1) ? 4 : (s == 2) ? 8 : 16));
      end
      measure(2, n);
      chk(n, MTF_ACCUM_DIV * 4);
      // rollover in special mode with divide by one
      bus(1'b1, MTF_OFS_MASK2, 32'h0);
      bus(1'b1, MTF_OFS_COUNT, 32'h0000_FFF0);
      bus(1'b0, MTF_OFS_COUNT, 32'h0);
      chk({31'h0, q >= 32'hFFF0}, 32'h1);
      bus(1'b0, MTF_OFS_FLAGS2, 32'h0);
      chk(q, 32'h0);
      // compare channel four hits on its value, counter one past it
      bus(1'b1, MTF_OFS_CHAN + 8'h10, 32'h0000_FFF8);
      n = 0;
      while (hit_o[4] !== 1'b1 && n < 200) begin
         @(posedge clk_i);
         n++;
      end
      chk({16'h0, count_o}, 32'h0000_FFF9);
      // capture strobe copies the running count into channel zero
      capture_i <= 4'h1;
      @(posedge clk_i);
      n = count_o;
      capture_i <= 4'h0;
      bus(1'b0, MTF_OFS_CHAN, 32'h0);
      chk(q, n);
      repeat (100) @(posedge clk_i);
      bus(1'b0, MTF_OFS_FLAGS2, 32'h0);
      chk(q, 32'h0000_0080);
      chk({31'h0, irq[0]}, 32'h0);
      bus(1'b1, MTF_OFS_FLAGS2, 32'h0);
      bus(1'b0, MTF_OFS_FLAGS2, 32'h0);
      chk(q, 32'h0000_0080);
      bus(1'b1, MTF_OFS_MASK2, 32'h0000_0080);
      @(posedge clk_i);
      chk({31'h0, irq[0]}, 32'h1);
      bus(1'b1, MTF_OFS_FLAGS2, 32'h0000_0080);
      bus(1'b0, MTF_OFS_FLAGS2, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, irq[0]}, 32'h0);
      // clearing write in the rollover cycle loses to the new flag
      bus(1'b1, MTF_OFS_COUNT, 32'h0000_FFF0);
      while (!(count_o == 16'hFFFF && ticks[1] === 1'b1)) begin
         @(posedge clk_i);
      end
      bus(1'b1, MTF_OFS_FLAGS2, 32'h0000_0080);
      bus(1'b0, MTF_OFS_FLAGS2, 32'h0);
      chk(q, 32'h0000_0080);
      bus(1'b1, MTF_OFS_FLAGS2, 32'h0000_0080);
      // periodic clock spacing and its flag
      measure(3, n);
      chk(n, MTF_PER_DIV * 4);
      bus(1'b0, MTF_OFS_FLAGS2, 32'h0);
      chk(q, 32'h0000_0040);
      chk({31'h0, irq[1]}, 32'h0);
      bus(1'b1, MTF_OFS_MASK2, 32'h0000_0040);
      @(posedge clk_i);
      chk({31'h0, irq[1]}, 32'h1);
      chk({31'h0, ticks[4]}, 32'h0);
      final_report();
   end

endmodule

`default_nettype wire
